// File: core/tom_defs.svh
// tom_defs.svh: field positions, codes and timing counts
// assumes a 20 MHz system clock; included by bare name
`ifndef TOM_DEFS_SVH
`define TOM_DEFS_SVH
`define TOM_CLK_HZ          20000000
`define TOM_STO_BIT         8
`define TOM_ERR_PWR_SHUT    16'h0001
`define TOM_ERR_ILL_SHUT    16'h0002
`define TOM_ERR_MIS_OFF     16'h0004
`define TOM_ERR_MIS_ON      16'h0006
`define TOM_WARN_SHUT       16'h0001
`define TOM_CODE_DUAL_ERR   8'h4D
`define TOM_CODE_DUAL_WARN  8'hA4
`define TOM_CODE_BRK_DIAG   8'hB7
`define TOM_CODE_COMM       8'hC1
`define TOM_CHATTER_US      1000
`define TOM_FILTER_US       2000
`define TOM_FILTER_CYC      ((`TOM_FILTER_US * (`TOM_CLK_HZ / 1000)) / 1000)
`define TOM_WAIT_UNIT_US    1000
`define TOM_WAIT_UNIT_CYC   ((`TOM_WAIT_UNIT_US * (`TOM_CLK_HZ / 1000)) / 1000)
`endif

// File: core/tom_pkg.sv
// tom_pkg.sv: types for the torque-off monitor
// assumes tom_defs.svh supplies all numeric constants
package tom_pkg;
   // stop sequencer states, gray along idle-brake-cut
   typedef enum logic [1:0] {
      TOM_IDLE  = 2'b00,
      TOM_BRAKE = 2'b01,
      TOM_CUT   = 2'b11
   } tom_stop_e;
endpackage : tom_pkg

// File: core/tom_monitor.sv
// tom_monitor.sv: dual-channel wired torque-off monitor and stop sequencer
// assumes synchronous inputs on i_clock, parameter words written by host
//
// Behaviour
// - echo outputs mirror each filtered input
// - either channel alone cuts motor energy
// - input change registered within 30ms
// - parameter bit 8 enables wired observation
// - energy cut independent of observation bit
// - sub-code 0001 on bit/input inconsistency
// - sub-code 0002 on request at servo on
// - sub-code 0004 on mismatch at servo off
// - sub-code 0006 on mismatch at servo on
// - errors stop axis, cleared only by reset
// - warning 0001 while inputs cut power and no error is held
// - warning clears itself when cause gone
// - report factor code with axis identity
// - brake circuit mismatch raises diag error, cut
// - communication failure raises alarm and cut
// - brake at once, cut after wait time
`timescale 1ns/1ps
`include "tom_defs.svh"
module tom_monitor #(
   parameter int FILTER_CYC = `TOM_FILTER_CYC,
   parameter int WAIT_UNIT  = `TOM_WAIT_UNIT_CYC,
   parameter int WAIT_W     = 16
) (
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   input  wire logic              i_torque_off_input_a,   // high: run
   input  wire logic              i_torque_off_input_b,   // high: run
   input  wire logic              i_spindle_sel,
   input  wire logic [15:0]       i_servo_function_set_eight,
   input  wire logic [15:0]       i_spindle_function_set_nine,
   input  wire logic [3:0]        i_axis_id,
   input  wire logic              i_servo_on,
   input  wire logic              i_controller_reset_clear,
   input  wire logic              i_ctrl_sto_req,
   input  wire logic [WAIT_W-1:0] i_cutoff_wait_time,
   input  wire logic              i_brake_side_a,
   input  wire logic              i_brake_side_b,
   input  wire logic              i_comm_fail,
   output logic                   o_torque_off_echo_a,
   output logic                   o_torque_off_echo_b,
   output logic                   o_power_enable,
   output logic                   o_brake_request,
   output logic                   o_dynamic_brake,
   output logic                   o_coast_stop,
   output logic                   o_safety_error_report,
   output logic                   o_safety_warning_report,
   output logic [7:0]             o_factor_code,
   output logic [15:0]            o_sub_code,
   output logic [3:0]             o_report_axis
);
   // refuse settings the filter and wait counters cannot serve
   initial begin
      if (FILTER_CYC < 2 || WAIT_UNIT < 1 || WAIT_W < 1 || WAIT_W > 24)
         $error("tom_monitor: bad parameters");
   end

   localparam int FW = $clog2(FILTER_CYC + 1);
   localparam int UW = $clog2(WAIT_UNIT + 1);

   logic [FW-1:0]     flt_cnt_a_r, flt_cnt_b_r;
   logic              sta_a_r, sta_b_r;         // filtered, high = run
   logic              err_r;
   logic [15:0]       err_code_r;
   logic [7:0]        err_fac_r;
   tom_pkg::tom_stop_e stop_r;
   logic [UW-1:0]     unit_cnt_r;
   logic [WAIT_W-1:0] wait_cnt_r;
   logic              obs_en;
   logic              wired_cut, mismatch, ctrl_cut, fatal;
   logic              fatal_sticky_r;

   // observation bit from the word of the active axis type
   assign obs_en = i_spindle_sel ?
                   i_spindle_function_set_nine[`TOM_STO_BIT] :
                   i_servo_function_set_eight[`TOM_STO_BIT];

   // channel a filter: accept a level only after it stays FILTER_CYC
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         flt_cnt_a_r <= '0;
         sta_a_r     <= 1'b0;
      end else if (i_torque_off_input_a == sta_a_r) begin
         flt_cnt_a_r <= '0;
      end else if (flt_cnt_a_r == FW'(FILTER_CYC - 1)) begin
         flt_cnt_a_r <= '0;
         sta_a_r     <= i_torque_off_input_a;
      end else begin
         flt_cnt_a_r <= flt_cnt_a_r + FW'(1);
      end
   end

   // channel b filter, same structure
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         flt_cnt_b_r <= '0;
         sta_b_r     <= 1'b0;
      end else if (i_torque_off_input_b == sta_b_r) begin
         flt_cnt_b_r <= '0;
      end else if (flt_cnt_b_r == FW'(FILTER_CYC - 1)) begin
         flt_cnt_b_r <= '0;
         sta_b_r     <= i_torque_off_input_b;
      end else begin
         flt_cnt_b_r <= flt_cnt_b_r + FW'(1);
      end
   end

   assign wired_cut = !sta_a_r || !sta_b_r;
   assign mismatch  = sta_a_r != sta_b_r;
   assign fatal     = (i_brake_side_a != i_brake_side_b) || i_comm_fail;

   // safety error capture (dual-signal, brake diag, link failure), held until controller reset
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         err_r      <= 1'b0;
         err_code_r <= 16'h0000;
         err_fac_r  <= 8'h00;
      end else if (!err_r) begin
         if (i_brake_side_a != i_brake_side_b) begin
            err_r <= 1'b1;
            err_fac_r <= `TOM_CODE_BRK_DIAG;
            err_code_r <= 16'h0001;
         end else if (i_comm_fail) begin
            err_r <= 1'b1;
            err_fac_r <= `TOM_CODE_COMM;
            err_code_r <= 16'h0001;
         end else if (!obs_en && wired_cut) begin
            err_r <= 1'b1;
            err_fac_r <= `TOM_CODE_DUAL_ERR;
            err_code_r <= `TOM_ERR_PWR_SHUT;
         end else if (obs_en && mismatch && i_servo_on) begin
            err_r <= 1'b1;
            err_fac_r <= `TOM_CODE_DUAL_ERR;
            err_code_r <= `TOM_ERR_MIS_ON;
         end else if (obs_en && mismatch) begin
            err_r <= 1'b1;
            err_fac_r <= `TOM_CODE_DUAL_ERR;
            err_code_r <= `TOM_ERR_MIS_OFF;
         end else if (obs_en && wired_cut && i_servo_on) begin
            err_r <= 1'b1;
            err_fac_r <= `TOM_CODE_DUAL_ERR;
            err_code_r <= `TOM_ERR_ILL_SHUT;
         end
      end else if (i_controller_reset_clear) begin
         err_r      <= 1'b0;
         err_code_r <= 16'h0000;
         err_fac_r  <= 8'h00;
      end
   end

   // fatal faults keep power cut until controller reset
   always_ff @(posedge i_clock) begin
      if (!i_rst_n)
         fatal_sticky_r <= 1'b0;
      else if (fatal)
         fatal_sticky_r <= 1'b1;
      else if (i_controller_reset_clear)
         fatal_sticky_r <= 1'b0;
   end

   assign ctrl_cut = i_ctrl_sto_req || fatal_sticky_r;

   // stop sequencer: brake first, cut power after the wait time
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         stop_r     <= tom_pkg::TOM_IDLE;
         unit_cnt_r <= '0;
         wait_cnt_r <= '0;
      end else begin
         case (stop_r)
            tom_pkg::TOM_IDLE: begin
               unit_cnt_r <= '0;
               wait_cnt_r <= '0;
               if (ctrl_cut)
                  stop_r <= tom_pkg::TOM_BRAKE;
            end
            tom_pkg::TOM_BRAKE: begin
               if (!ctrl_cut) begin
                  stop_r <= tom_pkg::TOM_IDLE;
               end else if (wait_cnt_r >= i_cutoff_wait_time) begin
                  stop_r <= tom_pkg::TOM_CUT;
               end else if (unit_cnt_r == UW'(WAIT_UNIT - 1)) begin
                  unit_cnt_r <= '0;
                  wait_cnt_r <= wait_cnt_r + WAIT_W'(1);
               end else begin
                  unit_cnt_r <= unit_cnt_r + UW'(1);
               end
            end
            tom_pkg::TOM_CUT: begin
               if (!ctrl_cut)
                  stop_r <= tom_pkg::TOM_IDLE;
            end
            default: stop_r <= tom_pkg::TOM_IDLE;
         endcase
      end
   end

   // echoes, power, brake and stop outputs
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_torque_off_echo_a <= 1'b0;
         o_torque_off_echo_b <= 1'b0;
         o_power_enable      <= 1'b0;
         o_brake_request     <= 1'b1;
         o_dynamic_brake     <= 1'b0;
         o_coast_stop        <= 1'b0;
      end else begin
         o_torque_off_echo_a <= sta_a_r;
         o_torque_off_echo_b <= sta_b_r;
         o_power_enable      <= !wired_cut && !err_r &&
                                stop_r != tom_pkg::TOM_CUT;
         o_brake_request     <= stop_r != tom_pkg::TOM_IDLE;
         o_dynamic_brake     <= err_r && !i_spindle_sel;
         o_coast_stop        <= err_r && i_spindle_sel;
      end
   end

   // report to controller: error takes priority over warning
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_safety_error_report   <= 1'b0;
         o_safety_warning_report <= 1'b0;
         o_factor_code           <= 8'h00;
         o_sub_code              <= 16'h0000;
         o_report_axis           <= 4'h0;
      end else begin
         o_report_axis <= i_axis_id;
         o_safety_error_report   <= err_r;
         o_safety_warning_report <= !err_r && wired_cut;
         if (err_r) begin
            o_factor_code <= err_fac_r;
            o_sub_code    <= err_code_r;
         end else if (wired_cut) begin
            o_factor_code <= `TOM_CODE_DUAL_WARN;
            o_sub_code    <= `TOM_WARN_SHUT;
         end else begin
            o_factor_code <= 8'h00;
            o_sub_code    <= 16'h0000;
         end
      end
   end

   property p_echo;
      @(posedge i_clock) disable iff (!i_rst_n)
      1 |=> (o_torque_off_echo_a == $past(sta_a_r)) &&
            (o_torque_off_echo_b == $past(sta_b_r));
   endproperty
   a_echo: assert property (p_echo) else $error("echo wrong");

   property p_either_cuts;
      @(posedge i_clock) disable iff (!i_rst_n)
      wired_cut |=> !o_power_enable;
   endproperty
   a_either_cuts: assert property (p_either_cuts)
      else $error("power on with a channel cut");

   property p_chatter;
      @(posedge i_clock) disable iff (!i_rst_n)
      $changed(sta_a_r) |-> $past(i_torque_off_input_a, 2) == sta_a_r;
   endproperty
   a_chatter: assert property (p_chatter)
      else $error("filter accepted a short pulse");

   property p_err_hold;
      @(posedge i_clock) disable iff (!i_rst_n)
      err_r && !i_controller_reset_clear |=> err_r;
   endproperty
   a_err_hold: assert property (p_err_hold)
      else $error("error cleared without reset");

   property p_warn;
      @(posedge i_clock) disable iff (!i_rst_n)
      !err_r && wired_cut |=> o_safety_warning_report &&
                              o_sub_code == 16'h0001;
   endproperty
   a_warn: assert property (p_warn)
      else $error("warning missing");

   property p_warn_clear;
      @(posedge i_clock) disable iff (!i_rst_n)
      !wired_cut |=> !o_safety_warning_report;
   endproperty
   a_warn_clear: assert property (p_warn_clear)
      else $error("warning stuck");

   property p_mis_off;
      @(posedge i_clock) disable iff (!i_rst_n)
      !err_r && !fatal && obs_en && mismatch && !i_servo_on
      |=> err_r && err_code_r == 16'h0004;
   endproperty
   a_mis_off: assert property (p_mis_off)
      else $error("mismatch at servo off not flagged");

   property p_brake_first;
      @(posedge i_clock) disable iff (!i_rst_n)
      stop_r == tom_pkg::TOM_IDLE && ctrl_cut
      |=> ##1 o_brake_request;
   endproperty
   a_brake_first: assert property (p_brake_first)
      else $error("brake not requested");

   property p_fatal;
      @(posedge i_clock) disable iff (!i_rst_n)
      fatal |=> fatal_sticky_r;
   endproperty
   a_fatal: assert property (p_fatal)
      else $error("fatal fault not latched");

endmodule : tom_monitor

// File: tb/tom_partner.sv
// tom_partner.sv: behavioural safety switch driving both wired channels
// assumes bench commands change on the falling clock edge
`timescale 1ns/1ps
module tom_partner #(
   parameter int HOLD_CYC = 30
) (
   input  wire logic i_clock,
   input  wire logic i_run_a,
   input  wire logic i_run_b,
   input  wire logic i_chatter_a,
   output logic      o_torque_off_input_a,
   output logic      o_torque_off_input_b
);
   logic lvl_a  = 1'b1;
   logic lvl_b  = 1'b1;
   int   hold_a = 0;
   int   hold_b = 0;

   // a new level is taken only once the last one has stood its time
   always @(negedge i_clock) begin
      if (hold_a > 0) begin
         hold_a <= hold_a - 1;
      end else if (i_run_a != lvl_a) begin
         lvl_a  <= i_run_a;
         hold_a <= HOLD_CYC;
      end
      if (hold_b > 0) begin
         hold_b <= hold_b - 1;
      end else if (i_run_b != lvl_b) begin
         lvl_b  <= i_run_b;
         hold_b <= HOLD_CYC;
      end
   end

   // contact bounce on channel a only when the bench commands it
   assign o_torque_off_input_a = lvl_a ^ i_chatter_a;
   assign o_torque_off_input_b = lvl_b;
endmodule : tom_partner

// File: tb/dual_channel_torque_off_monitor_tb.sv
// dual_channel_torque_off_monitor_tb.sv: self-checking bench for tom_monitor
// assumes tom_partner on the wired channels; filter 20, wait unit 4
`timescale 1ns/1ps
module dual_channel_torque_off_monitor_tb;
   localparam int FILT = 20;
   localparam int UNIT = 4;
   logic        i_clock = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        run_a = 1'b1, run_b = 1'b1, chat = 1'b0, spin = 1'b0;
   logic        bit8 = 1'b1, son = 1'b0, rclr = 1'b0, sreq = 1'b0;
   logic        bka = 1'b0, bkb = 1'b0, cfail = 1'b0;
   logic [15:0] wt = 16'h0003;
   logic [15:0] swd, swd9;
   logic [3:0]  ax = 4'hA;
   logic        sto_a, sto_b, echo_a, echo_b, pwr, brk, dyn, cst, err, wrn;
   logic [7:0]  code;
   logic [15:0] sub;
   logic [3:0]  axis;
   logic [15:0] sub_tab [4] = '{16'h0004, 16'h0006, 16'h0002, 16'h0001};
   int          fails = 0;
   int          checks = 0;

   // clock and the two words: the selected axis word carries bit8, the other its inverse
   always #25 i_clock = ~i_clock;
   assign swd  = (bit8 ^ spin) ? 16'h0100 : 16'h0000;
   assign swd9 = (bit8 ^ !spin) ? 16'h0100 : 16'h0000;

   tom_partner u_partner (.i_clock(i_clock), .i_run_a(run_a),
      .i_run_b(run_b), .i_chatter_a(chat), .o_torque_off_input_a(sto_a),
      .o_torque_off_input_b(sto_b));

   tom_monitor #(.FILTER_CYC(FILT), .WAIT_UNIT(UNIT), .WAIT_W(16)) DUT (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_torque_off_input_a(sto_a),
      .i_torque_off_input_b(sto_b), .i_spindle_sel(spin),
      .i_servo_function_set_eight(swd), .i_spindle_function_set_nine(swd9),
      .i_axis_id(ax), .i_servo_on(son), .i_controller_reset_clear(rclr),
      .i_ctrl_sto_req(sreq), .i_cutoff_wait_time(wt),
      .i_brake_side_a(bka), .i_brake_side_b(bkb), .i_comm_fail(cfail),
      .o_torque_off_echo_a(echo_a), .o_torque_off_echo_b(echo_b),
      .o_power_enable(pwr), .o_brake_request(brk), .o_dynamic_brake(dyn),
      .o_coast_stop(cst), .o_safety_error_report(err),
      .o_safety_warning_report(wrn), .o_factor_code(code),
      .o_sub_code(sub), .o_report_axis(axis));

   task automatic conclude();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task automatic chk16(input string what, input logic [15:0] got,
                        input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t ns: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk16

   task automatic chk1(input string what, input logic got, input logic exp);
      chk16(what, {15'h0000, got}, {15'h0000, exp});
   endtask : chk1

   task automatic cyc(input int n);
      repeat (n) @(negedge i_clock);
   endtask : cyc

   // bounded wait for both echoes, then room for the reports to follow
   task automatic wait_echo(input logic a, input logic b);
      int n;
      n = 0;
      while ({echo_a, echo_b} !== {a, b}) begin
         cyc(1);
         n++;
         if (n > 80) begin
            fails++;
            $display("Error %0t ns: echo wait ran out", $time);
            conclude();
         end
      end
      cyc(3);
   endtask : wait_echo

   task automatic rep(input string what, input logic [7:0] c,
                      input logic [15:0] s);
      chk16({what, " code"}, {8'h00, code}, {8'h00, c});
      chk16({what, " sub"}, sub, s);
      chk16({what, " axis"}, {12'h000, axis}, {12'h000, ax});
   endtask : rep

   // restore idle inputs, then clear through the controller reset
   task automatic clear(input string what, input logic held);
      run_a = 1'b1;
      run_b = 1'b1;
      son = 1'b0;
      bit8 = 1'b1;
      spin = 1'b0;
      wait_echo(1'b1, 1'b1);
      chk1("warning gone", wrn, 1'b0);
      chk1("error held", err, held);
      rclr = 1'b1;
      cyc(2);
      rclr = 1'b0;
      cyc(3);
      chk1("error cleared", err, 1'b0);
      chk1("power back", pwr, 1'b1);
      $display("test %s done", what);
   endtask : clear

   // main sequence
   initial begin
      int n;
      cyc(20);
      chk1("brake in reset", brk, 1'b1);
      chk1("power in reset", pwr, 1'b0);
      i_rst_n = 1'b1;
      wait_echo(1'b1, 1'b1);
      chk1("power", pwr, 1'b1);
      // legal request at servo off raises the warning only
      run_a = 1'b0;
      run_b = 1'b0;
      wait_echo(1'b0, 1'b0);
      chk1("power", pwr, 1'b0);
      chk1("warning", wrn, 1'b1);
      chk1("no error", err, 1'b0);
      rep("warning", 8'hA4, 16'h0001);
      clear("warning", 1'b0);
      // a bounce of half the filter time (FILT / 2 cycles) leaves the echo alone
      chat = 1'b1;
      cyc(FILT / 2);
      chat = 1'b0;
      cyc(FILT + 5);
      chk1("echo after bounce", echo_a, 1'b1);
      chk1("error after bounce", err, 1'b0);
      $display("test bounce done");
      // the four dual-signal error causes, servo and spindle stops
      for (int k = 0; k < 4; k++) begin
         son = (k == 1 || k == 2);
         spin = (k == 1);
         bit8 = (k != 3);
         ax = ax + 4'h1;
         // let the switch hold time run out so both channels move together
         cyc(32);
         run_a = 1'b0;
         run_b = (k != 2); // request at servo on when k is 2
         wait_echo(1'b0, run_b);
         chk1("power", pwr, 1'b0);
         chk1("error", err, 1'b1);
         chk1("dynamic", dyn, !spin);
         chk1("coast", cst, spin);
         rep("dual", 8'h4D, sub_tab[k]);
         clear("dual", 1'b1);
      end
      // brake circuit disagreement and link failure latch the cut
      for (int k = 0; k < 2; k++) begin
         bka = (k == 0);
         cfail = (k == 1);
         cyc(4);
         rep("fault", (k == 0) ? 8'hB7 : 8'hC1, 16'h0001);
         bka = 1'b0;
         cfail = 1'b0;
         cyc(4);
         chk1("power latched", pwr, 1'b0);
         clear("fault", 1'b1);
      end
      // controller stop: brake first, power cut after the wait time
      sreq = 1'b1;
      cyc(3);
      chk1("brake", brk, 1'b1);
      chk1("power", pwr, 1'b1);
      n = 0;
      while (pwr === 1'b1 && n < 60) begin
         cyc(1);
         n++;
      end
      chk1("cut not early", (n + 3) >= 3 * UNIT, 1'b1);
      chk1("cut in time", n < 60, 1'b1);
      sreq = 1'b0;
      cyc(3);
      chk1("brake released", brk, 1'b0);
      clear("stop", 1'b0);
      conclude();
   end
endmodule : dual_channel_torque_off_monitor_tb
